// [mosr_pkg.sv]
// package for the memory output stage reset controller
// assumes one port, one clock, registers reached over axi4-lite
package mosr_pkg;

    // register byte offsets
    localparam logic [3:0] CTRL_OFS   = 4'h0;   // control, read/write
    localparam logic [3:0] STATUS_OFS = 4'h4;   // state, read only
    localparam logic [3:0] DOUT_OFS   = 4'h8;   // output snapshot

    // control field positions
    localparam int PRIO_LSB      = 0;           // priority variant [2:0]
    localparam int LATCH_RST_BIT = 4;           // also reset the latch
    localparam int USE_REGISTER_STAGE_ENABLE_BIT = 5;           // register enable in use

    // status field positions
    localparam int ST_LATCH_EFF = 0;            // latch reset effective
    localparam int ST_PRIM      = 1;            // primitive register built
    localparam int ST_CORE      = 2;            // core register built
    localparam int ST_AT_RST    = 3;            // output holds reset value

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // reset priority variants
    typedef enum logic [2:0] {
        PRIO_LEGACY   = 3'b000,  // fixed: enables beat reset
        PRIO_CE_FIRST = 3'b001,  // selectable, enable first
        PRIO_RST_ALL  = 3'b010,  // reset first, latch and register
        PRIO_RST_REG  = 3'b011,  // reset first on register only
        PRIO_EN_GATED = 3'b100,  // both gated by port enable only
        PRIO_SPLIT    = 3'b101   // latch by enable, register by ce
    } mosr_prio_t;

    // control register layout
    typedef struct packed {
        logic       use_register_stage_enable;   // bit 5
        logic       latch_rst;   // bit 4
        logic       pad;         // bit 3, reads zero
        mosr_prio_t prio;        // bits 2:0
    } mosr_cfg_t;

endpackage : mosr_pkg

// [mosr_top.sv]
// read output stage of one memory port: latch, optional primitive
// register, optional core register, with configurable reset gating.
// assumes port controls synchronous to CLK_SYS and an axi4-lite master
// that keeps one write and one read outstanding at most.
`timescale 1ns/1ps

module mosr_top
    import mosr_pkg::*;
#(
    parameter int          DATA_W   = 16,         // word width
    parameter int          ADDR_W   = 8,          // word address width
    parameter bit          PRIM_REG = 1'b1,       // primitive register
    parameter bit          CORE_REG = 1'b0,       // core register
    parameter logic [15:0] RST_VAL  = 16'hFFFF    // output reset value
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RST_N,
    // user port
    input  wire logic              PORT_A_ENABLE,
    input  wire logic              PORT_A_WRITE_ENABLE,
    input  wire logic [ADDR_W-1:0] PORT_A_ADDR,
    input  wire logic [DATA_W-1:0] PORT_A_DIN,
    input  wire logic              PORT_A_RESET_IN,
    input  wire logic              PORT_A_REGISTER_STAGE_ENABLE,
    output logic      [DATA_W-1:0] PORT_A_DOUT,
    // axi4-lite slave
    input  wire logic [3:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic      [1:0]        S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [3:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic      [31:0]       S_AXI_RDATA,
    output logic      [1:0]        S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);

    // reset synchroniser and core signals
    logic              rst_meta_reg;            // first stage, sync only
    logic              rst_n_sync;              // released copy
    mosr_cfg_t         cfg_reg;                 // control register
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];   // storage array
    logic [DATA_W-1:0] rd_word;                 // addressed word
    logic [DATA_W-1:0] latch_reg;               // memory output latch
    logic [DATA_W-1:0] prim_reg;                // primitive register
    logic [DATA_W-1:0] core_reg;                // core register
    logic [DATA_W-1:0] rst_word;                // reset value at width
    logic              en;                      // port enable
    logic              rst;                     // port reset
    logic              ce_last;                 // last stage advance
    logic              latch_is_last;           // no register built
    logic              latch_eff;               // latch reset allowed
    logic              latch_rst_hit;           // latch resets now
    logic              reg_rst_hit;             // last register resets

    // gate for the latch reset under each priority variant
    function automatic logic latch_gate(input mosr_prio_t p,
                                        input logic       e);
        unique case (p)
            PRIO_RST_ALL: latch_gate = 1'b1;
            PRIO_LEGACY, PRIO_CE_FIRST, PRIO_RST_REG,
            PRIO_EN_GATED, PRIO_SPLIT:
                latch_gate = e;
            default:      latch_gate = e;             // unused code
        endcase
    endfunction : latch_gate

    // gate for the last register reset under each variant
    function automatic logic reg_gate(input mosr_prio_t p,
                                      input logic       e,
                                      input logic       c);
        unique case (p)
            PRIO_RST_ALL, PRIO_RST_REG: reg_gate = 1'b1;
            PRIO_EN_GATED:              reg_gate = e;
            PRIO_LEGACY, PRIO_CE_FIRST, PRIO_SPLIT:
                reg_gate = c;
            default:                    reg_gate = c;     // unused code
        endcase
    endfunction : reg_gate

    // reset release: async assert, two-flop release
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    // control decode
    always_comb begin
        en       = PORT_A_ENABLE;
        rst      = PORT_A_RESET_IN;
        rst_word = RST_VAL[DATA_W-1:0];     // fixed per port
        rd_word  = mem[PORT_A_ADDR];
        // register enable steers only the last stage
        ce_last  = cfg_reg.use_register_stage_enable ? PORT_A_REGISTER_STAGE_ENABLE
                                     : en;
        latch_is_last = !PRIM_REG && !CORE_REG;
        // latch reset offered only with primitive, no core
        latch_eff = cfg_reg.latch_rst && PRIM_REG && !CORE_REG;
        // declined: latch keeps data, only register resets
        latch_rst_hit = rst && (latch_is_last || latch_eff)
                        && latch_gate(cfg_reg.prio, en);
        // reset reaches the last register only
        reg_rst_hit = rst && !latch_is_last
                      && reg_gate(cfg_reg.prio, en, ce_last);
    end

    // storage writes, read-first towards the latch
    always_ff @(posedge CLK_SYS) begin
        if (en && PORT_A_WRITE_ENABLE) begin
            mem[PORT_A_ADDR] <= PORT_A_DIN;
        end
    end

    // memory output latch
    always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            latch_reg <= '0;
        end else if (latch_rst_hit) begin
            latch_reg <= rst_word;
        end else if (en) begin
            latch_reg <= rd_word;
        end
    end

    // primitive register: last stage unless a core register follows
    always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            prim_reg <= '0;
        end else if (!PRIM_REG) begin
            prim_reg <= '0;                           // not built
        end else if (!CORE_REG) begin
            if (reg_rst_hit) begin
                prim_reg <= rst_word;
            end else if (ce_last) begin
                prim_reg <= latch_reg;
            end
            // reset held or enables low keep it longer
        end else if (en) begin
            prim_reg <= latch_reg;
        end
    end

    // core register: always the last stage when built
    always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            core_reg <= '0;
        end else if (!CORE_REG) begin
            core_reg <= '0;                           // not built
        end else if (reg_rst_hit) begin
            core_reg <= rst_word;
        end else if (ce_last) begin
            core_reg <= PRIM_REG ? prim_reg : latch_reg;
        end
    end

    // output select, every choice is a flop
    assign PORT_A_DOUT = CORE_REG ? core_reg
                       : (PRIM_REG ? prim_reg : latch_reg);

    // ---------------- axi4-lite slave ----------------
    logic        aw_got_reg;    // address captured
    logic        w_got_reg;     // data captured
    logic [3:0]  awaddr_reg;    // held write address
    logic [31:0] wdata_reg;     // held write data
    logic [3:0]  wstrb_reg;     // held strobes
    logic        wr_fire;       // both halves present

    assign S_AXI_AWREADY = !aw_got_reg && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_got_reg && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign wr_fire       = aw_got_reg && w_got_reg;

    // write capture, either order; response once both arrived
    always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            awaddr_reg   <= '0;
            wdata_reg    <= '0;
            wstrb_reg    <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                // read-only words accept and ignore writes
                S_AXI_BRESP  <= (awaddr_reg == CTRL_OFS ||
                                 awaddr_reg == STATUS_OFS ||
                                 awaddr_reg == DOUT_OFS)
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // control register; only the low byte holds fields
    always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            cfg_reg <= mosr_cfg_t'(CTRL_RST[5:0]);
        end else if (wr_fire && awaddr_reg == CTRL_OFS && wstrb_reg[0]) begin
            cfg_reg           <= mosr_cfg_t'(wdata_reg[5:0]);
            cfg_reg.pad       <= 1'b0;          // reserved reads zero
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge CLK_SYS or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= '0;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= RESP_OKAY;
            S_AXI_RDATA  <= '0;
            unique case (S_AXI_ARADDR)
                CTRL_OFS:   S_AXI_RDATA[5:0] <= cfg_reg;
                STATUS_OFS: begin
                    S_AXI_RDATA[ST_LATCH_EFF] <= latch_eff;
                    S_AXI_RDATA[ST_PRIM]      <= PRIM_REG;
                    S_AXI_RDATA[ST_CORE]      <= CORE_REG;
                    S_AXI_RDATA[ST_AT_RST]    <= PORT_A_DOUT == rst_word;
                end
                DOUT_OFS:   S_AXI_RDATA[DATA_W-1:0] <= PORT_A_DOUT;
                default:    S_AXI_RRESP <= RESP_SLVERR;  // unmapped
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n_sync);

    property p_reg_reset_value;
        reg_rst_hit |=> PORT_A_DOUT == rst_word;
    endproperty
    a_reg_reset_value: assert property (p_reg_reset_value)
        else $error("last register missed reset value");

    property p_rst_first;
        (cfg_reg.prio == PRIO_RST_ALL && rst && !latch_is_last)
            |=> PORT_A_DOUT == rst_word;
    endproperty
    a_rst_first: assert property (p_rst_first)
        else $error("reset-first did not reset output");

    property p_ce_blocks_reset;
        (cfg_reg.prio == PRIO_CE_FIRST && rst && !ce_last
         && !latch_is_last) |=> PORT_A_DOUT === $past(PORT_A_DOUT);
    endproperty
    a_ce_blocks_reset: assert property (p_ce_blocks_reset)
        else $error("reset passed a low register enable");

    property p_en_gated;
        (cfg_reg.prio == PRIO_EN_GATED && reg_rst_hit) |-> en;
    endproperty
    a_en_gated: assert property (p_en_gated)
        else $error("enable-gated reset without enable");

    property p_latch_capture;
        (en && !latch_rst_hit) |=> latch_reg === $past(rd_word);
    endproperty
    a_latch_capture: assert property (p_latch_capture)
        else $error("latch failed to capture word");

    property p_latch_holds;
        (!en && !latch_rst_hit) |=> latch_reg === $past(latch_reg);
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("latch changed without enable");

    property p_two_cycle;
        (latch_eff && latch_rst_hit && reg_rst_hit) ##1 (ce_last && !rst)
            |-> PORT_A_DOUT == rst_word ##1 PORT_A_DOUT == rst_word;
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("latch reset did not give two cycles");

    property p_prim_latency;
        (PRIM_REG && !CORE_REG && ce_last && !reg_rst_hit)
            |=> PORT_A_DOUT === $past(latch_reg);
    endproperty
    a_prim_latency: assert property (p_prim_latency)
        else $error("primitive register latency wrong");

    property p_latch_offer;
        latch_rst_hit |-> (latch_is_last || (PRIM_REG && !CORE_REG));
    endproperty
    a_latch_offer: assert property (p_latch_offer)
        else $error("latch reset outside allowed build");

    property p_bvalid_hold;
        (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("write response dropped early");

    c_reg_reset:   cover property (reg_rst_hit ##1 !rst);
    c_two_cycle:   cover property (latch_eff && latch_rst_hit && reg_rst_hit);
    c_ce_blocked:  cover property (rst && !ce_last && !latch_is_last);
    c_ctrl_write:  cover property (wr_fire && awaddr_reg == CTRL_OFS);

endmodule : mosr_top

// [mosr_user_model.sv]
// user-side model: drives one memory port's controls each cycle
// assumes the bench calls drive() and the port clock is CLK_SYS
`timescale 1ns/1ps
module mosr_user_model (
    input  wire logic        clk,
    output logic             en,
    output logic             we,
    output logic [7:0]       addr,
    output logic [15:0]      din,
    output logic             rst,
    output logic             ce
);
    // idle port at time zero; the reset value is a build constant
    initial begin
        en   = 1'b0;
        we   = 1'b0;
        addr = 8'h00;
        din  = 16'h0000;
        rst  = 1'b0;
        ce   = 1'b0;
    end

    // one port cycle, launched just after a rising edge
    task automatic drive(input logic e, input logic w, input logic [7:0] a,
                         input logic [15:0] d, input logic r, input logic c);
        @(posedge clk);
        en   <= e;
        we   <= w;
        addr <= a;
        // unused write data toggles so a stale value is never trusted
        din  <= w ? d : ~din;
        rst  <= r;
        ce   <= c;
    endtask : drive
endmodule : mosr_user_model

// [mosr_top_tb_top.sv]
// self-checking bench for the memory output stage reset controller
// assumes mosr_top defaults: primitive register built, no core register
`timescale 1ns/1ps
module mosr_top_tb_top;
    import mosr_pkg::*;
    localparam logic [15:0] RV = 16'hFFFF;  // output reset value
    logic        clk, rst_n, en, we, rst, ce;
    logic [7:0]  addr;
    logic [15:0] din, dout;
    logic [3:0]  awaddr, araddr, wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;          // rd: last read data
    logic [1:0]  bresp, rresp, rr;          // rr: last read response
    logic [5:0]  cfg;                       // bench copy of control
    logic        model_on;                  // reference running
    logic [15:0] m_mem [0:255];             // reference array
    logic [15:0] m_latch, m_reg;            // reference stages
    logic [15:0] dout_bare, m_bare;         // latch-only build
    int          miscompares, n_compared;

    mosr_top #(.RST_VAL(RV)) dut_u (
        .CLK_SYS(clk), .RST_N(rst_n),
        .PORT_A_ENABLE(en), .PORT_A_WRITE_ENABLE(we),
        .PORT_A_ADDR(addr), .PORT_A_DIN(din), .PORT_A_RESET_IN(rst),
        .PORT_A_REGISTER_STAGE_ENABLE(ce), .PORT_A_DOUT(dout),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );
    // latch-only build shares the port and bus inputs; its bus outputs
    // stay open since the main instance answers the master
    mosr_top #(.PRIM_REG(1'b0), .RST_VAL(RV)) bare_u (
        .CLK_SYS(clk), .RST_N(rst_n),
        .PORT_A_ENABLE(en), .PORT_A_WRITE_ENABLE(we),
        .PORT_A_ADDR(addr), .PORT_A_DIN(din), .PORT_A_RESET_IN(rst),
        .PORT_A_REGISTER_STAGE_ENABLE(ce), .PORT_A_DOUT(dout_bare),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(), .S_AXI_BRESP(),
        .S_AXI_BVALID(), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(), .S_AXI_RDATA(),
        .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rready)
    );
    mosr_user_model user_u (.clk(clk), .en(en), .we(we), .addr(addr),
                            .din(din), .rst(rst), .ce(ce));

    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // which stages a reset reaches: {latch, last register}
    function automatic logic [1:0] hits(input logic [2:0] p, input logic lr,
                                        input logic r, input logic e,
                                        input logic c);
        logic lh, rh;
        lh = lr && r && ((p == 3'd2) ? 1'b1 : e);
        rh = r && ((p == 3'd2 || p == 3'd3) ? 1'b1 : ((p == 3'd4) ? e : c));
        return {lh, rh};
    endfunction : hits

    // reference stages, fed by the inputs sampled at each edge
    always @(posedge clk) begin : mdl
        logic       ce_l;
        logic [1:0] h;
        if (model_on) begin
            ce_l = cfg[5] ? ce : en;
            h = hits(cfg[2:0], cfg[4], rst, en, ce_l);
            if (h[0]) m_reg = RV;
            else if (ce_l) m_reg = m_latch;
            if (h[1]) m_latch = RV;
            else if (en) m_latch = m_mem[addr];
            // no register built: the reset lands on the latch itself
            if (rst && (cfg[2:0] == 3'd2 || en)) m_bare = RV;
            else if (en) m_bare = m_mem[addr];
            if (en && we) m_mem[addr] = din;
        end
    end

    // output checked every cycle where it has settled
    always @(negedge clk) begin
        if (model_on) begin
            check({16'h0, dout}, {16'h0, m_reg}, "port output");
            check({16'h0, dout_bare}, {16'h0, m_bare}, "latch only");
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check

    // one write; address and data offered together, each freed when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic ta, tw, ka, kw;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        while (!(ta && tw)) begin
            @(negedge clk);
            ka = !ta && awready;
            kw = !tw && wready;
            @(posedge clk);
            if (ka) awvalid <= 1'b0;
            if (kw) wvalid <= 1'b0;
            ta = ta | ka;
            tw = tw | kw;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        check({30'h0, bresp}, {30'h0, er}, "write response");
        @(posedge clk);
        bready <= 1'b0;
    endtask : axi_wr

    // one read; data and response taken at the falling edge that first sees rvalid
    task automatic axi_rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : axi_rd

    // idle the port first so the control change cannot move any stage
    task automatic set_cfg(input logic [5:0] c);
        user_u.drive(1'b0, 1'b0, 8'h00, 16'h0000, 1'b0, 1'b0);
        axi_wr(CTRL_OFS, {26'h0, c}, RESP_OKAY);
        cfg = c;
    endtask : set_cfg

    // one-cycle reset with enables high; count reset-value cycles
    task automatic pulse(input logic [5:0] c, input int exp_n);
        int n;
        set_cfg(c);
        repeat (3) user_u.drive(1'b1, 1'b0, 8'h01, 16'h0, 1'b0, 1'b1);
        user_u.drive(1'b1, 1'b0, 8'h01, 16'h0, 1'b1, 1'b1);
        n = 0;
        repeat (5) begin
            user_u.drive(1'b1, 1'b0, 8'h01, 16'h0, 1'b0, 1'b1);
            @(negedge clk);
            if (dout === RV) n++;
        end
        check(n, exp_n, "reset pulse length");
    endtask : pulse

    task automatic test_done();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // hang guard, well beyond the under two thousand cycles of the run
    initial begin
        #600000;
        miscompares++;
        test_done();
    end

    // main sequence
    initial begin
        miscompares = 0;
        n_compared = 0;
        {awaddr, araddr, wstrb, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {model_on, cfg, m_latch, m_reg, m_bare} = '0;
        void'($urandom(32'heb39c14e));
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        model_on = 1'b1;
        axi_rd(CTRL_OFS);
        check(rd, CTRL_RST, "control reset value");
        axi_wr(CTRL_OFS, 32'h0000_00FF, RESP_OKAY);
        axi_rd(CTRL_OFS);
        check(rd, 32'h0000_0037, "control readback");
        axi_wr(STATUS_OFS, 32'hFFFF_FFFF, RESP_OKAY);
        axi_wr(4'hC, 32'h0000_0001, RESP_SLVERR);
        axi_rd(4'hC);
        check({rd[29:0], rr}, {30'h0, RESP_SLVERR}, "unmapped read");
        set_cfg(6'h00);
        // known words at the low addresses; never the reset value
        for (int i = 0; i < 16; i++) begin
            user_u.drive(1'b1, 1'b1, 8'(i), 16'($urandom) & 16'h7FFF,
                         1'b0, 1'b0);
        end
        // every priority, latch-reset and register-enable setting
        for (int c = 0; c < 32; c++) begin
            set_cfg({c[4], c[3], 1'b0, c[2:0]});
            axi_rd(STATUS_OFS);
            check(rd & 32'hF, {28'h0, m_reg === RV, 2'b01, c[3]},
                  "status");
            repeat (40) begin
                user_u.drive($urandom % 4 != 0, $urandom % 8 == 0,
                             8'($urandom % 16), 16'($urandom) & 16'h7FFF,
                             $urandom % 4 == 0, $urandom % 4 != 0);
            end
        end
        pulse(6'h11, 2);
        pulse(6'h01, 1);
        user_u.drive(1'b0, 1'b0, 8'h00, 16'h0000, 1'b0, 1'b0);
        axi_rd(DOUT_OFS);
        check(rd, {16'h0, m_reg}, "output snapshot");
        test_done();
    end
endmodule : mosr_top_tb_top
